/* File: burst_fifo.v */
`timescale 1ns/1ps
module burst_fifo #(
  parameter W     = 16,
  parameter DEPTH = 16,
  parameter AW    = 4
) (
  // clock and reset
  input  wire          clk,
  input  wire          rst_n,
  // fill side
  input  wire          in_valid,
  input  wire [W-1:0]  in_data,
  output wire          in_ready,
  // drain side
  output wire          out_valid,
  output wire [W-1:0]  out_data,
  input  wire          out_ready
);
  reg [W-1:0]  mem [0:DEPTH-1];
  reg [AW-1:0] wr_ptr_r;
  reg [AW-1:0] rd_ptr_r;
  reg [AW:0]   count_r;
  reg [AW:0]   count_nxt;
  reg          in_ready_r;
  reg          out_valid_r;
  wire         push;
  wire         pop;

  assign push      = in_valid & in_ready_r;
  assign pop       = out_valid_r & out_ready;
  assign in_ready  = in_ready_r;
  assign out_valid = out_valid_r;
  assign out_data  = mem[rd_ptr_r];

  always @* begin
    count_nxt = count_r;
    if (push & ~pop)
      count_nxt = count_r + 1'b1;
    else if (pop & ~push)
      count_nxt = count_r - 1'b1;
  end

  always @(posedge clk) begin
    if (push)
      mem[wr_ptr_r] <= in_data;
  end

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_ptr_r    <= {AW{1'b0}};
      rd_ptr_r    <= {AW{1'b0}};
      count_r     <= {(AW+1){1'b0}};
      in_ready_r  <= 1'b0;
      out_valid_r <= 1'b0;
    end else begin
      if (push)
        wr_ptr_r <= wr_ptr_r + 1'b1;
      if (pop)
        rd_ptr_r <= rd_ptr_r + 1'b1;
      count_r     <= count_nxt;
      in_ready_r  <= (count_nxt != DEPTH[AW:0]);
      out_valid_r <= (count_nxt != {(AW+1){1'b0}});
    end
  end
endmodule // burst_fifo

/* File: flash_array_model.sv */
`timescale 1ns/1ps
module flash_array_model (
  // clock and control
  input  wire        ref_clk,
  input  wire        rstn,
  input  wire        stall,
  // page stream
  input  wire        array_req,
  input  wire [5:0]  array_page,
  input  wire        array_ready,
  output reg         array_valid,
  output reg  [15:0] array_data,
  // buffer ram
  input  wire        ram_we,
  input  wire [10:0] ram_addr,
  input  wire [15:0] ram_wdata,
  output reg  [15:0] ram_rdata
);
  reg     [15:0] mem [0:2047];
  reg     [10:0] left;
  reg     [9:0]  idx;
  reg     [5:0]  pg;
  integer        seed = 32'h03E5;
  always @(posedge ref_clk) begin
    ram_rdata <= mem[ram_addr];
    if (ram_we) mem[ram_addr] <= ram_wdata;
  end
  // word pattern carries page and index; released data is inverted
  always @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      array_valid <= 1'b0;
      array_data  <= 16'hFFFF;
      left        <= 11'h000;
      idx         <= 10'h000;
      pg          <= 6'h00;
    end else if (array_req) begin
      left <= 11'h400;
      idx  <= 10'h000;
      pg   <= array_page;
    end else if (array_valid && array_ready) begin
      array_valid <= 1'b0;
      array_data  <= ~array_data;
      left        <= left - 11'h001;
      idx         <= idx + 10'h001;
    end else if (!array_valid && left != 11'h000 && !(stall && $random(seed) % 2)) begin
      array_valid <= 1'b1;
      array_data  <= {pg, idx};
    end
  end
endmodule // flash_array_model

/* File: flash_burst_block_read.v */
`timescale 1ns/1ps
`include "flash_burst_map.vh"
module flash_burst_block_read (
  // clock and reset
  input  wire        ref_clk,
  input  wire        rstn,
  // command and configuration
  input  wire        cmd_start,
  input  wire [5:0]  start_page_address,
  input  wire [6:0]  page_count,
  input  wire [3:0]  buffer_sector_select,
  input  wire        sync_read_select,
  input  wire [2:0]  burst_len_sel,
  input  wire        lat_wr,
  input  wire [2:0]  lat_wdata,
  input  wire        cold_reset,
  input  wire        warm_reset,
  input  wire        hot_reset,
  // host bus pins
  input  wire        host_clk,
  input  wire        ce_n,
  input  wire        oe_n,
  input  wire        address_valid_n,
  input  wire [15:0] addr_in,
  output wire [15:0] dq_out,
  output wire        dq_oe,
  output wire        rdy,
  output wire        int_pin,
  output wire        int_bit,
  output wire [2:0]  read_latency_count,
  // flash array stream
  output wire        array_req,
  output wire [5:0]  array_page,
  input  wire        array_valid,
  input  wire [15:0] array_data,
  output wire        array_ready,
  // buffer ram
  output wire        ram_we,
  output wire [10:0] ram_addr,
  output wire [15:0] ram_wdata,
  input  wire [15:0] ram_rdata
);
  reg        rst_s1_r;
  reg        rst_s2_r;
  reg [3:0]  pin_s1_r;
  reg [3:0]  pin_s2_r;
  reg        hclk_d_r;
  reg [15:0] addr_s1_r;
  reg [15:0] addr_s2_r;
  reg [2:0]  st_r;
  reg [6:0]  pages_left_r;
  reg [5:0]  page_r;
  reg        buf_r;
  reg [10:0] load_cnt_r;
  reg [2:0]  lat_r;
  reg [2:0]  lat_cnt_r;
  reg [9:0]  word_addr_r;
  reg [10:0] burst_left_r;
  reg [10:0] page_words_r;
  reg        cont_r;
  reg        out_on_r;
  reg        int_r;
  reg        int_bit_r;
  reg        rdy_r;
  reg [15:0] dq_out_r;
  reg        dq_oe_r;
  reg        ram_we_r;
  reg [10:0] ram_addr_r;
  reg [15:0] ram_wdata_r;
  reg        array_req_r;
  reg [1:0]  rd_pend_r;
  wire       rst_n_i;
  wire       hrise;
  wire       ce_act;
  wire       oe_act;
  wire       avd_act;
  wire       any_reset;
  wire       latch;
  wire       fifo_valid;
  wire [15:0] fifo_data;
  wire       pop;
  wire       fifo_drain;
  wire       advance;
  wire [10:0] words_nxt;

  function [10:0] burst_words;
    input [2:0] sel;
    begin
      case (sel)
        `BL_4:   burst_words = 11'h004;
        `BL_8:   burst_words = 11'h008;
        `BL_16:  burst_words = 11'h010;
        `BL_32:  burst_words = 11'h020;
        `BL_1K:  burst_words = 11'h400;
        default: burst_words = 11'h400;
      endcase
    end
  endfunction

  // reset release
  always @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      rst_s1_r <= 1'b0;
      rst_s2_r <= 1'b0;
    end else begin
      rst_s1_r <= 1'b1;
      rst_s2_r <= rst_s1_r;
    end
  end
  assign rst_n_i = rst_s2_r;

  // host pins: {host_clk, ce_n, oe_n, address_valid_n}
  always @(posedge ref_clk or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pin_s1_r  <= 4'h7;
      pin_s2_r  <= 4'h7;
      hclk_d_r  <= 1'b0;
      addr_s1_r <= 16'h0000;
      addr_s2_r <= 16'h0000;
    end else begin
      pin_s1_r  <= {host_clk, ce_n, oe_n, address_valid_n};
      pin_s2_r  <= pin_s1_r;
      hclk_d_r  <= pin_s2_r[3];
      addr_s1_r <= addr_in;
      addr_s2_r <= addr_s1_r;
    end
  end

  assign hrise     = pin_s2_r[3] & ~hclk_d_r;
  assign ce_act    = ~pin_s2_r[2];
  assign oe_act    = ~pin_s2_r[1];
  assign avd_act   = ~pin_s2_r[0];
  assign any_reset = cold_reset | warm_reset | hot_reset;
  assign latch     = hrise & ce_act & avd_act &
                     ((st_r == `ST_READY) | (st_r == `ST_LAT) | (st_r == `ST_BURST));
  assign pop       = fifo_valid & (st_r == `ST_LOAD);
  // stale words of a load cut short by a reset are dropped while idle
  assign fifo_drain = (st_r == `ST_LOAD) | (st_r == `ST_IDLE);
  // a word is captured by the host on every rising host clock edge of the burst phase with address valid released
  assign advance   = hrise & ce_act & (st_r == `ST_BURST) & ~avd_act;
  assign words_nxt = page_words_r + 11'h001;

  burst_fifo #(
    .W     (`WORD_W),
    .DEPTH (`FIFO_DEPTH),
    .AW    (`FIFO_AW)
  ) u_fifo (
    .clk       (ref_clk),
    .rst_n     (rst_n_i),
    .in_valid  (array_valid),
    .in_data   (array_data),
    .in_ready  (array_ready),
    .out_valid (fifo_valid),
    .out_data  (fifo_data),
    .out_ready (fifo_drain)
  );

  always @(posedge ref_clk or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st_r         <= `ST_IDLE;
      pages_left_r <= 7'h00;
      page_r       <= 6'h00;
      buf_r        <= 1'b0;
      load_cnt_r   <= 11'h000;
      lat_r        <= `LAT_DEFAULT;
      lat_cnt_r    <= 3'h0;
      word_addr_r  <= 10'h000;
      burst_left_r <= 11'h000;
      page_words_r <= 11'h000;
      cont_r       <= 1'b0;
      out_on_r     <= 1'b0;
      int_r        <= 1'b0;
      int_bit_r    <= 1'b0;
      rdy_r        <= 1'b0;
      dq_out_r     <= 16'h0000;
      dq_oe_r      <= 1'b0;
      ram_we_r     <= 1'b0;
      ram_addr_r   <= 11'h000;
      ram_wdata_r  <= 16'h0000;
      array_req_r  <= 1'b0;
      rd_pend_r    <= 2'h0;
    end else begin
      array_req_r <= 1'b0;
      ram_we_r    <= 1'b0;
      rd_pend_r   <= {rd_pend_r[0], 1'b0};
      if (rd_pend_r[1])
        dq_out_r <= ram_rdata;
      // bit follows the length now selected, so a host can poll it before latching
      int_bit_r <= int_r & (burst_len_sel != `BL_CONT);
      dq_oe_r   <= ce_act & oe_act & out_on_r;
      if (lat_wr && (lat_wdata >= `LAT_MIN))
        lat_r <= lat_wdata;
      if (any_reset) begin
        st_r        <= `ST_IDLE;
        int_r       <= 1'b0;
        rdy_r       <= 1'b0;
        out_on_r    <= 1'b0;
        array_req_r <= 1'b0;
        if (cold_reset)
          lat_r <= `LAT_DEFAULT;
      end else begin
        if (!ce_act)
          out_on_r <= 1'b0;
        case (st_r)
          `ST_IDLE: begin
            if (cmd_start) begin
              page_r       <= start_page_address;
              pages_left_r <= page_count;
              buf_r        <= buffer_sector_select[`BUF1_BIT];
              load_cnt_r   <= 11'h000;
              array_req_r  <= 1'b1;
              st_r         <= `ST_LOAD;
            end
          end
          `ST_LOAD: begin
            if (pop) begin
              ram_we_r    <= 1'b1;
              ram_addr_r  <= {buf_r, load_cnt_r[9:0]};
              ram_wdata_r <= fifo_data;
              load_cnt_r  <= load_cnt_r + 11'h001;
              if (load_cnt_r == (`PAGE_WORDS - 11'h001)) begin
                int_r        <= 1'b1;
                page_words_r <= 11'h000;
                st_r         <= `ST_READY;
              end
            end
          end
          `ST_READY, `ST_LAT, `ST_BURST: begin
            if (latch) begin
              out_on_r <= 1'b1;
              rdy_r    <= 1'b0;
              if (addr_s2_r == `LAT_CFG_ADDR) begin
                dq_out_r <= {13'h0000, lat_r};
              end else begin
                // spare bits of the address are dropped
                word_addr_r  <= addr_s2_r[9:0];
                ram_addr_r   <= {buf_r, addr_s2_r[9:0]};
                rd_pend_r    <= 2'h1;
                lat_cnt_r    <= lat_r;
                cont_r       <= (burst_len_sel == `BL_CONT);
                burst_left_r <= burst_words(burst_len_sel);
                // async mode still yields the first word
                st_r <= sync_read_select ? `ST_LAT : `ST_READY;
              end
            end else if (!ce_act && (st_r != `ST_READY)) begin
              rdy_r <= 1'b0;
              st_r  <= `ST_READY;
            end else if (hrise && (st_r == `ST_LAT)) begin
              lat_cnt_r <= lat_cnt_r - 3'h1;
              if (lat_cnt_r == 3'h1) begin
                rdy_r <= 1'b1;
                st_r  <= `ST_BURST;
              end
            end else if (advance) begin
              rdy_r <= 1'b0;
              if (cont_r || (burst_left_r != 11'h000)) begin
                if (!cont_r)
                  burst_left_r <= burst_left_r - 11'h001;
                // fixed bursts stop at the page end, continuous wraps
                if (cont_r || (word_addr_r != 10'h3FF)) begin
                  word_addr_r <= word_addr_r + 10'h001;
                  ram_addr_r  <= {buf_r, word_addr_r + 10'h001};
                  rd_pend_r   <= 2'h1;
                end
                page_words_r <= words_nxt;
                if (words_nxt == `PAGE_WORDS) begin
                  int_r    <= 1'b0;
                  out_on_r <= 1'b0;
                  if (pages_left_r <= 7'h01) begin
                    st_r <= `ST_IDLE;
                  end else begin
                    // next page goes to the other buffer
                    pages_left_r <= pages_left_r - 7'h01;
                    page_r       <= page_r + 6'h01;
                    buf_r        <= ~buf_r;
                    load_cnt_r   <= 11'h000;
                    array_req_r  <= 1'b1;
                    st_r         <= `ST_LOAD;
                  end
                end
              end
            end
          end
          default: st_r <= `ST_IDLE;
        endcase
      end
    end
  end

  // every fixed or continuous length is accepted on a loaded page
  assign dq_out             = dq_out_r;
  assign dq_oe              = dq_oe_r;
  assign rdy                = rdy_r;
  assign int_pin            = int_r;
  assign int_bit            = int_bit_r;
  assign read_latency_count = lat_r;
  assign array_req          = array_req_r;
  assign array_page         = page_r;
  assign ram_we             = ram_we_r;
  assign ram_addr           = ram_addr_r;
  assign ram_wdata          = ram_wdata_r;
endmodule // flash_burst_block_read

/* File: flash_burst_block_read_props.sv */
`timescale 1ns/1ps
module flash_burst_block_read_props (
  // clock and reset
  input wire       ref_clk,
  input wire       rstn,
  // controls and pins
  input wire       lat_wr,
  input wire [2:0] lat_wdata,
  input wire       cold_reset,
  input wire       warm_reset,
  input wire       hot_reset,
  input wire       ce_n,
  input wire       oe_n,
  // outputs watched
  input wire       dq_oe,
  input wire       int_pin,
  input wire       int_bit,
  input wire [2:0] read_latency_count,
  input wire       array_req,
  input wire       ram_we
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rstn);
  a_req_pulse: assert property (array_req |=> !array_req)
    else $error("page request longer than one cycle");
  a_int_rise_load: assert property ($rose(int_pin) |-> ram_we || $past(ram_we))
    else $error("indicator rose without a finished load");
  a_load_int_low: assert property (ram_we |-> !$past(int_pin))
    else $error("buffer written while indicator high");
  a_int_bit_lag: assert property (int_bit |-> $past(int_pin))
    else $error("indicator bit set without pin");
  a_lat_range: assert property (read_latency_count >= 3'h3)
    else $error("latency below three");
  a_lat_write: assert property (lat_wr && lat_wdata >= 3'h3 && !cold_reset
    |=> read_latency_count == $past(lat_wdata)) else $error("latency write lost");
  a_lat_ignore: assert property (lat_wr && lat_wdata < 3'h3 && !cold_reset
    |=> $stable(read_latency_count)) else $error("illegal latency accepted");
  a_lat_cold: assert property (cold_reset |=> read_latency_count == 3'h4)
    else $error("cold reset kept latency");
  a_reset_ends: assert property (cold_reset || warm_reset || hot_reset
    |=> !int_pin && !array_req) else $error("mode survived reset");
  a_oe_release: assert property ((ce_n || oe_n) [*4] |-> !dq_oe)
    else $error("data driven while deselected");
  a_oe_cause: assert property ($rose(dq_oe) |-> !$past(ce_n, 3) && !$past(oe_n, 3))
    else $error("drive began without select");
endmodule // flash_burst_block_read_props
bind flash_burst_block_read flash_burst_block_read_props props (.ref_clk, .rstn, .lat_wr,
  .lat_wdata, .cold_reset, .warm_reset, .hot_reset, .ce_n, .oe_n, .dq_oe, .int_pin,
  .int_bit, .read_latency_count, .array_req, .ram_we);

/* File: flash_burst_block_read_tb.sv */
`timescale 1ns/1ps
module flash_burst_block_read_tb;
  reg         ref_clk = 0, rstn = 0, cmd_start = 0, sync_read_select = 1, lat_wr = 0;
  reg         cold_reset = 0, warm_reset = 0, hot_reset = 0, host_clk = 0, stall = 1;
  reg         ce_n = 1, oe_n = 1, address_valid_n = 1;
  reg  [5:0]  start_page_address = 0;
  reg  [6:0]  page_count = 7'h03;
  reg  [3:0]  buffer_sector_select = 4'h8;
  reg  [2:0]  burst_len_sel = 0, lat_wdata = 0, lat;
  reg  [15:0] addr_in = 0;
  wire [15:0] dq_out, array_data, ram_wdata, ram_rdata;
  wire [10:0] ram_addr;
  wire [5:0]  array_page;
  wire [2:0]  read_latency_count;
  wire        dq_oe, rdy, int_pin, int_bit, array_req, array_valid, array_ready, ram_we;
  integer     n_mismatch = 0, n_compared = 0, n_req = 0, seed = 32'h03E5, i, p, k;
  integer     exp_q[$];
  flash_burst_block_read dut (
    .ref_clk(ref_clk), .rstn(rstn), .cmd_start(cmd_start),
    .start_page_address(start_page_address), .page_count(page_count),
    .buffer_sector_select(buffer_sector_select), .sync_read_select(sync_read_select),
    .burst_len_sel(burst_len_sel), .lat_wr(lat_wr), .lat_wdata(lat_wdata),
    .cold_reset(cold_reset), .warm_reset(warm_reset), .hot_reset(hot_reset),
    .host_clk(host_clk), .ce_n(ce_n), .oe_n(oe_n), .address_valid_n(address_valid_n),
    .addr_in(addr_in), .dq_out(dq_out), .dq_oe(dq_oe), .rdy(rdy), .int_pin(int_pin),
    .int_bit(int_bit), .read_latency_count(read_latency_count), .array_req(array_req),
    .array_page(array_page), .array_valid(array_valid), .array_data(array_data),
    .array_ready(array_ready), .ram_we(ram_we), .ram_addr(ram_addr), .ram_wdata(ram_wdata),
    .ram_rdata(ram_rdata)
  );
  flash_array_model far (
    .ref_clk(ref_clk), .rstn(rstn), .stall(stall), .array_req(array_req),
    .array_page(array_page), .array_ready(array_ready), .array_valid(array_valid),
    .array_data(array_data), .ram_we(ram_we), .ram_addr(ram_addr), .ram_wdata(ram_wdata),
    .ram_rdata(ram_rdata)
  );
  always #2.5 ref_clk = ~ref_clk;
  always @(posedge ref_clk) if (array_req === 1'b1) n_req <= n_req + 1;
  task chk(input [15:0] got, input [15:0] exp);
    begin
      n_compared = n_compared + 1;
      if (got !== exp) begin
        n_mismatch = n_mismatch + 1;
        $display("Error at %0t: seen %h expected %h", $time, got, exp);
      end
    end
  endtask
  task wrap_up;
    begin
      $display("compared %0d mismatches %0d", n_compared, n_mismatch);
      if (n_mismatch == 0 && n_compared > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
    end
  endtask
  // one host clock period, ends just before the next rising edge
  task hedge;
    begin
      @(negedge ref_clk) host_clk = 1;
      repeat (4) @(negedge ref_clk);
      host_clk = 0;
      repeat (3) @(negedge ref_clk);
    end
  endtask
  task wint(input v);
    begin
      k = 0;
      while (int_pin !== v && k < 20000) begin
        @(negedge ref_clk);
        k = k + 1;
      end
      chk(int_pin, v);
    end
  endtask
  task setlat(input [2:0] v);
    begin
      lat_wdata = v;
      lat_wr = 1;
      @(negedge ref_clk) lat_wr = 0;
      @(negedge ref_clk);
    end
  endtask
  task pulse_cmd;
    begin
      cmd_start = 1;
      @(negedge ref_clk) cmd_start = 0;
    end
  endtask
  initial begin
    #450000;
    n_mismatch = n_mismatch + 1;
    wrap_up;
  end
  initial begin
    repeat (6) @(negedge ref_clk);
    rstn = 1;
    repeat (5) @(negedge ref_clk);
    chk(read_latency_count, 4);
    for (i = 7; i >= 2; i = i - 1) begin
      setlat(i);
      chk(read_latency_count, i < 3 ? 3 : i);
    end
    cold_reset = 1;
    @(negedge ref_clk) cold_reset = 0;
    @(negedge ref_clk);
    chk(read_latency_count, 4);
    lat = 3 + {$random(seed)} % 5;
    setlat(lat);
    start_page_address = {$random(seed)} % 62;
    pulse_cmd;
    for (p = 0; p < 3; p = p + 1) begin
      for (i = 0; i < 1024; i = i + 1) exp_q.push_back((start_page_address + p) * 1024 + i);
      wint(1);
      burst_len_sel = (p == 0) ? 3'h0 : 3'h5;
      ce_n = 0;
      oe_n = 0;
      address_valid_n = 0;
      addr_in = (p == 1) ? 16'hF0F0 : 16'h0000;
      repeat (3) @(negedge ref_clk);
      chk(int_bit, p != 0);
      if (p == 1) begin
        repeat (3) hedge;
        chk(dq_out[2:0], lat);
        sync_read_select = 0;
        addr_in = 16'h0004;
        hedge;
        chk(dq_out, exp_q[4]);
        sync_read_select = 1;
        addr_in = 16'h0000;
      end
      hedge;
      address_valid_n = 1;
      for (i = 1; i < lat; i = i + 1) hedge;
      chk(rdy, 0);
      hedge;
      chk(rdy, 1);
      for (i = 0; i < 1024; i = i + 1) begin
        chk(dq_out, exp_q.pop_front());
        if (i == 1023) chk(dq_oe, 1);
        hedge;
      end
      wint(0);
      ce_n = 1;
      oe_n = 1;
      repeat (5) @(negedge ref_clk);
      chk(dq_oe, 0);
    end
    repeat (4000) @(negedge ref_clk);
    chk(int_pin, 0);
    chk(n_req, 3);
    for (p = 0; p < 2; p = p + 1) begin
      pulse_cmd;
      repeat (300) @(negedge ref_clk);
      hot_reset = (p == 0);
      warm_reset = (p != 0);
      @(negedge ref_clk);
      hot_reset = 0;
      warm_reset = 0;
      repeat (4000) @(negedge ref_clk);
      chk(int_pin, 0);
      chk(n_req, 4 + p);
    end
    wrap_up;
  end
endmodule // flash_burst_block_read_tb

/* File: flash_burst_map.vh */
// Function
// - pages follow automatically after one command
// - only main area data is delivered
// - indicator rises when page load completes
// - indicator falls itself after page read
// - continuous uses pin only; fixed uses both
// - first word after latency, later words each edge
// - latency defaults four, programmable three to seven
// - first data captured on edge n plus one
// - ready pulses one clock before first capture
// - new word each edge, address self-increments
// - continuous read runs to the end of the page
// - fixed bursts 4..1K words, no wrap
// - normal burst modes accepted on loaded page
// - first word delivered even in async mode
// - latency readable by address during burst
// - outputs released when select or enable high
`ifndef FLASH_BURST_MAP_VH
`define FLASH_BURST_MAP_VH
`define WORD_W        16
`define FIFO_DEPTH    16
`define FIFO_AW       4
`define PAGE_WORDS    11'h400
`define LAT_DEFAULT   3'h4
`define LAT_MIN       3'h3
`define LAT_CFG_ADDR  16'hF0F0
`define BUF1_BIT      2
`define BL_CONT       3'h0
`define BL_4          3'h1
`define BL_8          3'h2
`define BL_16         3'h3
`define BL_32         3'h4
`define BL_1K         3'h5
`define ST_IDLE       3'h0
`define ST_LOAD       3'h1
`define ST_READY      3'h2
`define ST_LAT        3'h3
`define ST_BURST      3'h4
`endif
